// *** hdl/irq_slice_defines.svh ***
// Register offsets, reset values, field masks and bus codes for the interrupt slice
`ifndef IRQ_SLICE_DEFINES_SVH
`define IRQ_SLICE_DEFINES_SVH

// Byte offsets of the word-aligned registers
`define OFS_EN_TWO      8'h00
`define OFS_EN_THREE    8'h04
`define OFS_PRIO_ONE    8'h08
`define OFS_PRIO_TWO    8'h0C
`define OFS_PRIO_THREE  8'h10
`define OFS_CTRL        8'h14
`define OFS_PENDING     8'h18
`define OFS_IRQ_STS     8'h1C
`define OFS_IRQ_MSK     8'h20
`define WORD_MASK       8'hFC

// Reset values and implemented-bit masks
`define RST_EN          8'h00
`define RST_PRIO        8'hFF
`define MASK_EN_TWO     8'h0F
`define MASK_EN_THREE   8'h3F
`define MASK_PRIO_ONE   8'hFF
`define MASK_PRIO_TWO   8'h5F
`define MASK_PRIO_THREE 8'h3F

// Control and status bit positions
`define CTRL_GPE_BIT    0
`define STS_HI_BIT      0
`define STS_LO_BIT      1

// AXI4-Lite response codes
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// *** hdl/irq_slice_pkg.sv ***
// Types shared by the interrupt enable and priority slice
package irq_slice_pkg;

   // Peripheral requests, grouped by the register that governs them
   typedef struct packed {
      logic [5:0] three;
      logic [3:0] two;
      logic [7:0] one;
   } src_s;

   // Second enable register, low implemented half
   typedef struct packed {
      logic [3:0] unused;
      logic       bus_collision_irq_en;
      logic       low_voltage_irq_en;
      logic       timer_three_ovf_irq_en;
      logic       capcomp_two_irq_en;
   } en_two_s;

   // Third enable register
   typedef struct packed {
      logic [1:0] unused;
      logic       serial_two_rx_irq_en;
      logic       serial_two_tx_irq_en;
      logic       timer_four_match_irq_en;
      logic       capcomp_five_irq_en;
      logic       capcomp_four_irq_en;
      logic       capcomp_three_irq_en;
   } en_three_s;

   // Whole state of the slice
   typedef struct packed {
      logic        aw_rdy;
      logic        w_rdy;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [7:0]  wdata;
      logic        wbe;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      en_two_s     en2;
      en_three_s   en3;
      logic [7:0]  p1;
      logic [7:0]  p2;
      logic [7:0]  p3;
      logic        gpe;
      src_s        gated;
      logic        irq_hi;
      logic        irq_lo;
      logic [1:0]  sts;
      logic [1:0]  msk;
      logic        irq;
   } state_s;

endpackage : irq_slice_pkg

// *** hdl/peripheral_irq_enable_priority.sv ***
// Peripheral interrupt enable and priority slice with an AXI4-Lite register port
//
// What this block does
// RULE1: Enable bit 3 gates bus collision request
// RULE2: Enable bit 2 gates low-voltage detect request
// RULE3: Enable bit 1 gates timer three overflow
// RULE4: Enable bit 0 gates capture/compare two
// RULE5: Third register bits 5,4 gate serial two
// RULE6: Every source has its own priority bit
// RULE7: Exactly three priority registers are provided
// RULE8: Priority bits act only with global enable
// RULE9: Priority one is high, zero is low
// RULE10: Third register bits 3..0 gate timer/capcomp
// RULE11: Global enable clear gives one single level
`timescale 1ns/1ps
`include "irq_slice_defines.svh"

module peripheral_irq_enable_priority
   import irq_slice_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and synchronous reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address and data
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output      logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output      logic              wready,
   // AXI4-Lite write response
   output      logic [1:0]        bresp,
   output      logic              bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output      logic              arready,
   output      logic [31:0]       rdata,
   output      logic [1:0]        rresp,
   output      logic              rvalid,
   input  wire logic              rready,
   // Raw peripheral requests
   input  wire src_s              src_req,
   // Gated requests and priority levels toward the core
   output      src_s              req_gated,
   output      logic              irq_high,
   output      logic              irq_low,
   // Software interrupt line
   output      logic              irq
);

   // Reset image of the whole state
   localparam state_s RST_STATE = '{
      aw_rdy : 1'b1, w_rdy : 1'b1, aw_got : 1'b0, w_got : 1'b0,
      awaddr : '0, wdata : '0, wbe : 1'b0,
      bvalid : 1'b0, bresp : `RESP_OKAY,
      ar_rdy : 1'b1, rvalid : 1'b0, rresp : `RESP_OKAY, rdata : '0,
      en2 : en_two_s'(`RST_EN), en3 : en_three_s'(`RST_EN),
      p1 : `RST_PRIO & `MASK_PRIO_ONE,
      p2 : `RST_PRIO & `MASK_PRIO_TWO,
      p3 : `RST_PRIO & `MASK_PRIO_THREE,
      gpe : 1'b0, gated : '0, irq_hi : 1'b0, irq_lo : 1'b0,
      sts : '0, msk : '0, irq : 1'b0
   };

   state_s     st_q;
   state_s     st_d;
   src_s       en_v;
   src_s       pr_v;
   src_s       gated;
   logic       wr_go;
   logic [1:0] sts_clr;
   logic [1:0] ev;
   logic [7:0] wa;
   logic [7:0] ra;

   // Outputs straight from the state flops
   assign awready   = st_q.aw_rdy;
   assign wready    = st_q.w_rdy;
   assign bvalid    = st_q.bvalid;
   assign bresp     = st_q.bresp;
   assign arready   = st_q.ar_rdy;
   assign rvalid    = st_q.rvalid;
   assign rresp     = st_q.rresp;
   assign rdata     = st_q.rdata;
   assign req_gated = st_q.gated;
   assign irq_high  = st_q.irq_hi;
   assign irq_low   = st_q.irq_lo;
   assign irq       = st_q.irq;

   // Next-state logic: bus slave, register file, gating, sticky status
   always_comb
   begin
      st_d    = st_q;
      sts_clr = '0;
      wa      = st_q.awaddr & `WORD_MASK;
      ra      = 8'(araddr) & `WORD_MASK;

      // Address and data are taken independently, in either order
      if (awvalid && st_q.aw_rdy)
      begin
         st_d.aw_rdy = 1'b0;
         st_d.aw_got = 1'b1;
         st_d.awaddr = 8'(awaddr);
      end
      if (wvalid && st_q.w_rdy)
      begin
         st_d.w_rdy = 1'b0;
         st_d.w_got = 1'b1;
         st_d.wdata = wdata[7:0];
         st_d.wbe   = wstrb[0];
      end
      if (st_q.bvalid && bready)
      begin
         st_d.bvalid = 1'b0;
      end

      // Write commits once both halves are held and no response is pending
      wr_go = st_q.aw_got && st_q.w_got && !st_q.bvalid;
      if (wr_go)
      begin
         st_d.aw_got = 1'b0;
         st_d.w_got  = 1'b0;
         st_d.aw_rdy = 1'b1;
         st_d.w_rdy  = 1'b1;
         st_d.bvalid = 1'b1;
         st_d.bresp  = `RESP_OKAY;
         case (wa)
            `OFS_EN_TWO:
            begin
               if (st_q.wbe)
                  st_d.en2 = en_two_s'(st_q.wdata & `MASK_EN_TWO);
            end
            `OFS_EN_THREE:
            begin
               if (st_q.wbe)
                  st_d.en3 = en_three_s'(st_q.wdata & `MASK_EN_THREE);
            end
            `OFS_PRIO_ONE:
            begin
               if (st_q.wbe)
                  st_d.p1 = st_q.wdata & `MASK_PRIO_ONE; // RULE6
            end
            `OFS_PRIO_TWO:
            begin
               if (st_q.wbe)
                  st_d.p2 = st_q.wdata & `MASK_PRIO_TWO; // RULE7
            end
            `OFS_PRIO_THREE:
            begin
               if (st_q.wbe)
                  st_d.p3 = st_q.wdata & `MASK_PRIO_THREE; // RULE7
            end
            `OFS_CTRL:
            begin
               if (st_q.wbe)
                  st_d.gpe = st_q.wdata[`CTRL_GPE_BIT];
            end
            `OFS_IRQ_STS:
            begin
               if (st_q.wbe)
                  sts_clr = st_q.wdata[1:0];
            end
            `OFS_IRQ_MSK:
            begin
               if (st_q.wbe)
                  st_d.msk = st_q.wdata[1:0];
            end
            `OFS_PENDING:
            begin
               // Read-only; write accepted and dropped
            end
            default:
            begin
               st_d.bresp = `RESP_SLVERR;
            end
         endcase
      end

      // One read in flight; data latched with the address
      if (arvalid && st_q.ar_rdy)
      begin
         st_d.ar_rdy = 1'b0;
         st_d.rvalid = 1'b1;
         st_d.rresp  = `RESP_OKAY;
         case (ra)
            `OFS_EN_TWO:     st_d.rdata = 32'(st_q.en2);
            `OFS_EN_THREE:   st_d.rdata = 32'(st_q.en3);
            `OFS_PRIO_ONE:   st_d.rdata = 32'(st_q.p1);
            `OFS_PRIO_TWO:   st_d.rdata = 32'(st_q.p2);
            `OFS_PRIO_THREE: st_d.rdata = 32'(st_q.p3);
            `OFS_CTRL:       st_d.rdata = 32'(st_q.gpe);
            `OFS_PENDING:    st_d.rdata = 32'(st_q.gated);
            `OFS_IRQ_STS:    st_d.rdata = 32'(st_q.sts);
            `OFS_IRQ_MSK:    st_d.rdata = 32'(st_q.msk);
            default:
            begin
               st_d.rdata = '0;
               st_d.rresp = `RESP_SLVERR;
            end
         endcase
      end
      if (st_q.rvalid && rready)
      begin
         st_d.rvalid = 1'b0;
         st_d.ar_rdy = 1'b1;
      end

      // Enable vector; first-group sources arrive already enabled upstream
      en_v.one   = '1;
      en_v.two   = {st_q.en2.bus_collision_irq_en,         // RULE1
                    st_q.en2.low_voltage_irq_en,           // RULE2
                    st_q.en2.timer_three_ovf_irq_en,       // RULE3
                    st_q.en2.capcomp_two_irq_en};          // RULE4
      en_v.three = {st_q.en3.serial_two_rx_irq_en,         // RULE5
                    st_q.en3.serial_two_tx_irq_en,         // RULE5
                    st_q.en3.timer_four_match_irq_en,      // RULE10
                    st_q.en3.capcomp_five_irq_en,          // RULE10
                    st_q.en3.capcomp_four_irq_en,          // RULE10
                    st_q.en3.capcomp_three_irq_en};        // RULE10
      gated      = src_req & en_v;

      // One priority bit per source, drawn from the three registers
      pr_v.one   = st_q.p1;          // RULE6
      pr_v.two   = 4'(st_q.p2);      // RULE6
      pr_v.three = 6'(st_q.p3);      // RULE6

      // Without the global enable everything lands on the high line
      st_d.gated = gated;
      if (st_q.gpe)
      begin
         st_d.irq_hi = |(gated & pr_v);   // RULE8 RULE9
         st_d.irq_lo = |(gated & ~pr_v);  // RULE9
      end
      else
      begin
         st_d.irq_hi = |gated;            // RULE11
         st_d.irq_lo = 1'b0;              // RULE11
      end

      // Sticky status on rising levels; a new event beats a same-cycle clear
      ev[`STS_HI_BIT] = st_d.irq_hi && !st_q.irq_hi;
      ev[`STS_LO_BIT] = st_d.irq_lo && !st_q.irq_lo;
      st_d.sts        = (st_q.sts & ~sts_clr) | ev;
      st_d.irq        = |(st_d.sts & st_d.msk);
   end

   // Single state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         st_q <= RST_STATE;
      else
         st_q <= st_d;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Gating checks
   chk_bcl_block: assert property ( // RULE1
      !st_q.en2.bus_collision_irq_en && !$rose(st_q.en2.bus_collision_irq_en)
         |=> !req_gated.two[3])
      else $error("bus collision request passed while disabled");

   chk_lvd_gate: assert property ( // RULE2
      src_req.two[2] && st_q.en2.low_voltage_irq_en |=> req_gated.two[2])
      else $error("low-voltage request not forwarded");

   chk_timer_three_gate: assert property ( // RULE3
      ##1 req_gated.two[1] == $past(src_req.two[1] && st_q.en2.timer_three_ovf_irq_en))
      else $error("timer three gating wrong");

   chk_capcomp_unit_two_gate: assert property ( // RULE4
      (src_req.two[0] && !st_q.en2.capcomp_two_irq_en)
         ##1 !st_q.en2.capcomp_two_irq_en |-> !req_gated.two[0])
      else $error("capcomp two request leaked");

   chk_serial_two: assert property ( // RULE5
      ##1 req_gated.three[5:4] == $past(src_req.three[5:4]
         & {st_q.en3.serial_two_rx_irq_en, st_q.en3.serial_two_tx_irq_en}))
      else $error("serial two gating wrong");

   chk_ccp_three: assert property ( // RULE10
      ##1 req_gated.three[3:0] == $past(src_req.three[3:0] & 4'(st_q.en3)))
      else $error("timer four or capcomp gating wrong");

   // Priority checks
   chk_prio_high: assert property ( // RULE6
      st_q.gpe && src_req.one[0] && st_q.p1[0] |=> irq_high)
      else $error("high-priority source missed high line");

   chk_prio_low: assert property ( // RULE9
      st_q.gpe && (src_req & en_v & ~pr_v) != '0 |=> irq_low)
      else $error("low-priority source missed low line");

   chk_flat_level: assert property ( // RULE11
      !st_q.gpe |=> !irq_low && (irq_high == ($past(src_req & en_v) != '0)))
      else $error("single level mode not honoured");

   // Two flat cycles in a row, so the line depends only on requests and enables
   chk_prio_ignored: assert property ( // RULE8
      !st_q.gpe && !$past(st_q.gpe) && $stable(src_req) && $stable(en_v)
         && $changed(pr_v) |=> $stable(irq_high))
      else $error("priority bits acted without global enable");

   chk_hi_needs_hi: assert property ( // RULE9
      st_q.gpe && (src_req & en_v & pr_v) == '0 |=> !irq_high)
      else $error("high line raised without high-priority source");

   chk_lo_needs_lo: assert property ( // RULE9
      st_q.gpe && (src_req & en_v & ~pr_v) == '0 |=> !irq_low)
      else $error("low line raised without low-priority source");

   chk_prio_regs: assert property ( // RULE7
      st_q.p2 == (st_q.p2 & `MASK_PRIO_TWO) && st_q.p3 == (st_q.p3 & `MASK_PRIO_THREE))
      else $error("unimplemented priority bits set");

   // Status and interrupt output checks
   chk_sts_sticky: assert property (
      $rose(irq_high) |-> st_q.sts[`STS_HI_BIT])
      else $error("status missed rising high line");

   chk_irq_level: assert property (
      st_q.sts[`STS_HI_BIT] && st_q.msk[`STS_HI_BIT] ##1 st_q.sts[`STS_HI_BIT]
         && st_q.msk[`STS_HI_BIT] |-> irq)
      else $error("unmasked status without interrupt");

   // Status, interrupt and bus answer checks
   chk_sts_low: assert property (
      $rose(irq_low) |-> st_q.sts[`STS_LO_BIT])
      else $error("status missed rising low line");

   chk_irq_idle: assert property (
      (st_q.sts & st_q.msk) == '0 |-> !irq)
      else $error("interrupt without unmasked status");

   chk_wr_answer: assert property (
      st_q.aw_got && st_q.w_got && !st_q.bvalid |=> bvalid)
      else $error("write committed without response");

   chk_rd_answer: assert property (
      arvalid && arready |=> rvalid)
      else $error("read taken without data");

endmodule : peripheral_irq_enable_priority

// *** verif/periph_src_model.sv ***
// Peripheral request source model feeding raw requests to the slice
`timescale 1ns/1ps

module periph_src_model
   import irq_slice_pkg::*;
(
   // Clock
   input  wire logic aclk,
   // Request pattern commanded by the bench
   input  wire src_s want,
   // Raw level requests toward the slice
   output      src_s src_req = '0
);
   // Peripherals change their flags just after the edge, like real flops
   always @(posedge aclk)
   begin
      src_req <= want;
   end
endmodule : periph_src_model

// *** verif/peripheral_irq_enable_priority_test.sv ***
// Self-checking bench for the peripheral interrupt enable and priority slice
`timescale 1ns/1ps
`include "irq_slice_defines.svh"

module peripheral_irq_enable_priority_test
   import irq_slice_pkg::*;
;
   logic        aclk    = '0;
   logic        aresetn = '0;
   logic [7:0]  awaddr  = '0;
   logic [7:0]  araddr  = '0;
   logic        awvalid = '0;
   logic        wvalid  = '0;
   logic        arvalid = '0;
   logic [31:0] wdata   = '0;
   // Handshake readies held high; the master may assert them early
   logic        bready  = '1;
   logic        rready  = '1;
   logic [3:0]  wstrb   = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        irq_high, irq_low, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   src_s        want    = '0;
   src_s        src_req, req_gated;
   int          err_total       = 0;
   int          samples_checked = 0;

   peripheral_irq_enable_priority i_peripheral_irq_enable_priority (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .awaddr    (awaddr),
      .awvalid   (awvalid),
      .awready   (awready),
      .wdata     (wdata),
      .wstrb     (wstrb),
      .wvalid    (wvalid),
      .wready    (wready),
      .bresp     (bresp),
      .bvalid    (bvalid),
      .bready    (bready),
      .araddr    (araddr),
      .arvalid   (arvalid),
      .arready   (arready),
      .rdata     (rdata),
      .rresp     (rresp),
      .rvalid    (rvalid),
      .rready    (rready),
      .src_req   (src_req),
      .req_gated (req_gated),
      .irq_high  (irq_high),
      .irq_low   (irq_low),
      .irq       (irq)
   );
   periph_src_model i_periph_src_model (.aclk(aclk), .want(want), .src_req(src_req));

   // 10 MHz clock
   initial
   begin
      forever #50 aclk = ~aclk;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick

   // Write one word; each channel drops valid at its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= '1;
      wvalid  <= '1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= '0;
         if (wready) wvalid <= '0;
      end while (!bvalid);
      check("bresp", 32'(bresp), 32'(`RESP_OKAY));
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= '1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= '0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      check("rdata", d, e);
      check("rresp", 32'(r), 32'(`RESP_OKAY));
   endtask : rc

   // Reset values of every register, then an unmapped read
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  e [9] = '{8'h00, 8'h00, 8'hFF, 8'h5F, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++)
         rc(8'(4 * i), {24'h0, e[i]});
      rd(8'h24, d, r);
      check("unmapped_data", d, 32'h0);
      check("unmapped_resp", 32'(r), 32'(`RESP_SLVERR));
   endtask : t_reset

   // Walk a single set enable bit across both registers, all sources raised
   task automatic t_enable;
      logic [9:0] m;
      want <= '1;
      for (int i = 0; i < 10; i++)
      begin
         m = 10'h1 << i;
         wr(`OFS_EN_TWO, {4'h0, m[3:0]});
         wr(`OFS_EN_THREE, {2'h0, m[9:4]});
         tick(4);
         check("gated", 32'(req_gated), 32'({m, 8'hFF}));
      end
      wr(`OFS_EN_TWO, 8'hFF);
      wr(`OFS_EN_THREE, 8'hFF);
      // Write without the low lane strobe must leave the register alone
      wstrb <= 4'h0;
      wr(`OFS_EN_TWO, 8'h00);
      wstrb <= 4'hF;
      rc(`OFS_EN_TWO, 32'h0F);
      rc(`OFS_EN_THREE, 32'h3F);
      rc(`OFS_PENDING, 32'h3FFFF);
   endtask : t_enable

   // One source at a time, its own priority bit flipped low then high
   task automatic t_priority;
      logic [7:0] a;
      int         b;
      wr(`OFS_CTRL, 8'h01);
      for (int j = 0; j < 18; j++)
      begin
         a = j < 8 ? `OFS_PRIO_ONE : j < 12 ? `OFS_PRIO_TWO : `OFS_PRIO_THREE;
         b = j < 8 ? j : j < 12 ? j - 8 : j - 12;
         want <= src_s'(18'h1 << j);
         wr(a, 8'h00);
         tick(4);
         check("level_low", 32'({irq_high, irq_low}), 32'h1);
         wr(a, 8'(1 << b));
         tick(4);
         check("level_high", 32'({irq_high, irq_low}), 32'h2);
      end
      rc(`OFS_IRQ_STS, 32'h3);
      wr(a, 8'h00);
      wr(`OFS_CTRL, 8'h00);
      tick(4);
      check("single_level", 32'({irq_high, irq_low}), 32'h2);
      // Priority change while flat; the source stays low priority
      wr(a, 8'h1F);
      tick(4);
      check("prio_ignored", 32'({irq_high, irq_low}), 32'h2);
   endtask : t_priority

   // Sticky status, mask gating and write-one-to-clear of the line
   task automatic t_irq;
      want <= '0;
      wr(`OFS_IRQ_STS, 8'h03);
      rc(`OFS_IRQ_STS, 32'h0);
      want <= src_s'(18'h1);
      tick(4);
      rc(`OFS_IRQ_STS, 32'h1);
      check("irq_masked", 32'(irq), 32'h0);
      wr(`OFS_IRQ_MSK, 8'h01);
      tick(2);
      check("irq_on", 32'(irq), 32'h1);
      wr(`OFS_IRQ_STS, 8'h01);
      tick(2);
      check("irq_cleared", 32'(irq), 32'h0);
      rc(`OFS_IRQ_STS, 32'h0);
   endtask : t_irq

   // Reset in mid-run; requests dropped first so no status sets after release
   task automatic t_rerst;
      want    <= '0;
      tick(4);
      aresetn <= '0;
      tick(3);
      aresetn <= '1;
      tick(1);
      check("rst_lines", 32'({irq_high, irq_low, irq}), 32'h0);
      check("rst_gated", 32'(req_gated), 32'h0);
      t_reset();
   endtask : t_rerst

   // Main sequence
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= '1;
      tick(1);
      t_reset();
      t_enable();
      t_priority();
      t_irq();
      t_rerst();
      finish_test();
   end

   // Watchdog well beyond the expected run of about five hundred cycles
   initial
   begin
      repeat (20000) @(posedge aclk);
      err_total++;
      finish_test();
   end
endmodule : peripheral_irq_enable_priority_test
